// ### design/ahp_pkg.sv
// Shared constants for the converter parallel host port
`default_nettype none
package ahp_pkg;
  localparam int DATA_W = 12;             // Result and bus width
  localparam int CTRL_W = 10;             // Control data width below the address lines
  localparam int ADDR_LO = 10;            // Bus bit carrying register address bit 0
  localparam int ADDR_HI = 11;            // Bus bit carrying register address bit 1
  localparam int PIPE_DEPTH = 5;          // Conversion clock cycles of latency
  localparam int FIFO_DEPTH = 8;          // Result buffer depth
  localparam int WORD_W = DATA_W + 1;     // Result plus first-channel flag
  localparam int PIN_W = 17;              // Synchronised pin vector width
  localparam int SYNC_STAGES = 3;         // Flip-flops on every pin input
  // Positions in the synchronised pin vector
  localparam int PIN_SEL_LO = 16;
  localparam int PIN_SEL_HI = 15;
  localparam int PIN_ACCESS = 14;
  localparam int PIN_RD = 13;
  localparam int PIN_CONV = 12;
  // Control register addresses and fields
  localparam logic [1:0] ADDR_CTRL0 = 2'h0;
  localparam logic [1:0] ADDR_CTRL1 = 2'h1;
  localparam int CTRL0_REF_EXT = 0;       // 1: external reference
  localparam int CTRL0_CHAN_LO = 1;       // Channels sampled minus one, two bits
  localparam int CTRL1_STROBE_SEP = 0;    // 1: separate write and read strobes
  localparam logic [CTRL_W-1:0] CTRL0_RESET = 10'h000;
  localparam logic [CTRL_W-1:0] CTRL1_RESET = 10'h000;
  localparam logic [2:0] PIPE_FULL = 3'h5;
endpackage : ahp_pkg
`default_nettype wire

// ### design/ahp_stream_if.sv
// Valid/ready word carrier between the port and its result buffer
`default_nettype none
interface ahp_stream_if #(parameter int W = 13);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : ahp_stream_if
`default_nettype wire

// ### design/ahp_fifo.sv
// Synchronous result FIFO with valid/ready on both sides
`default_nettype none
module ahp_fifo #(
  parameter int W = 13,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  ahp_stream_if.snk wr,
  ahp_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wptr_r;
  logic [AW-1:0] rptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  // ----------------------------------------
  // Handshakes
  // ----------------------------------------
  // Room is measured on the wider count so a full buffer of DEPTH words is not mistaken for empty
  assign wr.ready = (count_r < (AW+1)'(DEPTH));
  assign rd.valid = (count_r != '0);
  assign rd.data = mem_r[rptr_r];
  assign push = wr.valid && wr.ready;
  assign pop = rd.valid && rd.ready;

  // Storage has no reset; only pointers and the occupancy count carry control state
  always_ff @(posedge sys_clk_in) begin
    if (push) begin
      mem_r[wptr_r] <= wr.data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      wptr_r <= '0;
      rptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wptr_r <= (wptr_r == AW'(DEPTH - 1)) ? '0 : wptr_r + 1'b1;
      end
      if (pop) begin
        rptr_r <= (rptr_r == AW'(DEPTH - 1)) ? '0 : rptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : ahp_fifo
`default_nettype wire

// ### design/ahp_host_port.sv
// Parallel host port of a four-input pipelined converter: strobes, control registers, result path
// Contract
// - Low-active select must be low for any access to count.
// - High-active select must also be high for the device to respond.
// - Results travel on twelve bus lines, bit 0 least significant.
// - On a register write, bus bit ten carries address bit zero.
// - On a register write, bus bit eleven carries address bit one.
// - Address bits choose control register zero or one for the write.
// - Access input can act as combined read/write direction.
// - Alternatively access input is a low-active write strobe.
// - Read strobe counts only in separate-strobe mode, active low.
// - Multichannel mode: sync output marks first channel's result on the bus.
// - Control register zero selects internal or external reference.
// - Result appears five conversion clock cycles after its start edge.
// - A conversion starts on every falling conversion clock edge.
// - Sync low with first-channel data in multichannel; off single-channel.
// - Effective read strobe combines both selects and the read strobe; in combined mode the code uses the access input in its place.
`default_nettype none
module ahp_host_port (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic conversion_clock_in,
  input wire logic select_low_n_in,
  input wire logic select_high_in,
  input wire logic access_in,
  input wire logic read_n_in,
  input wire logic [ahp_pkg::DATA_W-1:0] data_in,
  input wire logic [ahp_pkg::DATA_W-1:0] sample_in,
  output logic [ahp_pkg::DATA_W-1:0] data_out,
  output logic data_oe_out,
  output logic sync_n_out,
  output logic ref_external_out,
  output logic [ahp_pkg::CTRL_W-1:0] control0_out,
  output logic [ahp_pkg::CTRL_W-1:0] control1_out,
  output logic overrun_out
);
  import ahp_pkg::*;

  logic [PIN_W-1:0] pin_s_r [SYNC_STAGES];
  logic [PIN_W-1:0] flt_r;
  logic conv_prev_r;
  logic wr_prev_r;
  logic rd_prev_r;
  logic [DATA_W-1:0] wr_data_r;
  logic [CTRL_W-1:0] ctrl0_r;
  logic [CTRL_W-1:0] ctrl1_r;
  logic [WORD_W-1:0] pipe_r [PIPE_DEPTH];
  logic [2:0] fill_r;
  logic [1:0] chan_r;
  logic selected;
  logic strobe_sep;
  logic wr_active;
  logic rd_active;
  logic conv_fall;
  logic wr_end;
  logic rd_start;
  logic [1:0] chan_last;
  logic multichannel;
  ahp_stream_if #(.W(WORD_W)) in_s ();
  ahp_stream_if #(.W(WORD_W)) out_s ();

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Three stages per pin; the filtered copy only moves when stages two and three agree
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < SYNC_STAGES; i++) begin
        pin_s_r[i] <= 17'h1E000;
      end
      flt_r <= 17'h1E000;
    end else begin
      pin_s_r[0] <= {select_low_n_in, select_high_in, access_in, read_n_in, conversion_clock_in, data_in};
      for (int i = 1; i < SYNC_STAGES; i++) begin
        pin_s_r[i] <= pin_s_r[i-1];
      end
      for (int b = 0; b < PIN_W; b++) begin
        if (pin_s_r[1][b] == pin_s_r[2][b]) begin
          flt_r[b] <= pin_s_r[2][b];
        end
      end
    end
  end

  // ----------------------------------------
  // Strobe decode
  // ----------------------------------------
  assign selected = !flt_r[PIN_SEL_LO] && flt_r[PIN_SEL_HI];
  assign strobe_sep = ctrl1_r[CTRL1_STROBE_SEP];
  // Combined mode: access high reads, low writes; separate mode: access is write strobe
  assign wr_active = selected && !flt_r[PIN_ACCESS];
  assign rd_active = selected && (strobe_sep ? !flt_r[PIN_RD] : flt_r[PIN_ACCESS]);
  assign conv_fall = conv_prev_r && !flt_r[PIN_CONV];
  assign wr_end = wr_prev_r && !wr_active;
  assign rd_start = rd_active && !rd_prev_r;
  assign chan_last = ctrl0_r[CTRL0_CHAN_LO +: 2];
  assign multichannel = (chan_last != 2'h0);

  // Edge history of the decoded strobes and the conversion clock
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      conv_prev_r <= 1'b0;
      wr_prev_r <= 1'b0;
      rd_prev_r <= 1'b0;
    end else begin
      conv_prev_r <= flt_r[PIN_CONV];
      wr_prev_r <= wr_active;
      rd_prev_r <= rd_active;
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  // Data is committed at the end of the strobe so the host's settled value is taken
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      wr_data_r <= 12'h000;
      ctrl0_r <= CTRL0_RESET;
      ctrl1_r <= CTRL1_RESET;
    end else begin
      if (wr_active) begin
        wr_data_r <= flt_r[DATA_W-1:0];
      end
      if (wr_end) begin
        // Addresses two and three hold no register and are ignored
        if ({wr_data_r[ADDR_HI], wr_data_r[ADDR_LO]} == ADDR_CTRL0) begin
          ctrl0_r <= wr_data_r[CTRL_W-1:0];
        end
        if ({wr_data_r[ADDR_HI], wr_data_r[ADDR_LO]} == ADDR_CTRL1) begin
          ctrl1_r <= wr_data_r[CTRL_W-1:0];
        end
      end
    end
  end

  // Register mirrors; reference choice drives the analog switch
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      ref_external_out <= 1'b0;
      control0_out <= CTRL0_RESET;
      control1_out <= CTRL1_RESET;
    end else begin
      ref_external_out <= ctrl0_r[CTRL0_REF_EXT];
      control0_out <= ctrl0_r;
      control1_out <= ctrl1_r;
    end
  end

  // ----------------------------------------
  // Conversion pipeline
  // ----------------------------------------
  // One stage per conversion clock; clock must run freely or results stall in flight
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < PIPE_DEPTH; i++) begin
        pipe_r[i] <= 13'h0000;
      end
      fill_r <= 3'h0;
      chan_r <= 2'h0;
    end else if (conv_fall) begin
      pipe_r[0] <= {(chan_r == 2'h0), sample_in};
      for (int i = 1; i < PIPE_DEPTH; i++) begin
        pipe_r[i] <= pipe_r[i-1];
      end
      if (fill_r != PIPE_FULL) begin
        fill_r <= fill_r + 3'h1;
      end
      chan_r <= (chan_r >= chan_last) ? 2'h0 : chan_r + 2'h1;
    end
  end

  // Fifth start edge after a sample hands it to the buffer
  assign in_s.valid = conv_fall && (fill_r == PIPE_FULL);
  assign in_s.data = pipe_r[PIPE_DEPTH-1];
  assign out_s.ready = rd_start;

  ahp_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .wr(in_s),
    .rd(out_s)
  );

  // Host too slow: result lost, flagged until the end of the next write strobe at any address
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      overrun_out <= 1'b0;
    end else if (in_s.valid && !in_s.ready) begin
      overrun_out <= 1'b1;
    end else if (wr_end) begin
      overrun_out <= 1'b0;
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Each read opening pops one word; an empty buffer repeats the last word
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      data_out <= 12'h000;
      sync_n_out <= 1'b1;
      data_oe_out <= 1'b0;
    end else begin
      data_oe_out <= rd_active;
      if (rd_start && out_s.valid) begin
        data_out <= out_s.data[DATA_W-1:0];
        sync_n_out <= !(multichannel && out_s.data[DATA_W]);
      end else if (!multichannel) begin
        sync_n_out <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);

  property p_oe_follows_read;
    rd_active |=> data_oe_out;
  endproperty
  a_oe_follows_read: assert property (p_oe_follows_read) else $error("bus not driven during read");

  property p_float_idle;
    !rd_active |=> !data_oe_out;
  endproperty
  a_float_idle: assert property (p_float_idle) else $error("bus driven outside read");

  property p_unselected_quiet;
    (flt_r[PIN_SEL_LO] || !flt_r[PIN_SEL_HI]) |=> !data_oe_out && !wr_prev_r;
  endproperty
  a_unselected_quiet: assert property (p_unselected_quiet) else $error("access without both selects");

  property p_rd_ignored_combined;
    (!strobe_sep && flt_r[PIN_ACCESS] == 1'b0) |=> !data_oe_out;
  endproperty
  a_rd_ignored_combined: assert property (p_rd_ignored_combined) else $error("read in combined write");

  property p_ctrl0_write;
    wr_end && wr_data_r[ADDR_HI:ADDR_LO] == ADDR_CTRL0 |=> ##1 ref_external_out == $past(wr_data_r[0], 2);
  endproperty
  a_ctrl0_write: assert property (p_ctrl0_write) else $error("reference choice not taken");

  property p_unmapped_write;
    wr_end && wr_data_r[ADDR_HI] |=> $stable(ctrl0_r) && $stable(ctrl1_r);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped address changed a register");

  property p_latency;
    conv_fall && fill_r == PIPE_FULL |-> in_s.valid ##1 pipe_r[PIPE_DEPTH-1] == $past(pipe_r[PIPE_DEPTH-2]);
  endproperty
  a_latency: assert property (p_latency) else $error("result not released after five cycles");

  property p_sync_single;
    !multichannel |=> sync_n_out;
  endproperty
  a_sync_single: assert property (p_sync_single) else $error("sync active in single channel");

  property p_read_word;
    rd_start && out_s.valid |=> data_out == $past(out_s.data[DATA_W-1:0]);
  endproperty
  a_read_word: assert property (p_read_word) else $error("read did not present buffer head");

  c_ctrl1_write: cover property (wr_end && wr_data_r[ADDR_HI:ADDR_LO] == ADDR_CTRL1);
  c_sync_low: cover property (!sync_n_out && data_oe_out);
  c_overrun: cover property (in_s.valid && !in_s.ready);
  c_sep_read: cover property (strobe_sep && rd_start);
endmodule : ahp_host_port
`default_nettype wire

// ### verification/ahp_host_model.sv
// Host bus master model driving the converter port pins
`default_nettype none
module ahp_host_model
  import ahp_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic [ahp_pkg::DATA_W-1:0] dut_data_in,
  input wire logic dut_oe_in,
  output logic select_low_n_out,
  output logic select_high_out,
  output logic access_out,
  output logic read_n_out,
  output logic [ahp_pkg::DATA_W-1:0] bus_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drive = 1'h0;
  logic [DATA_W-1:0] wdata = 12'h000;
  logic [DATA_W-1:0] last = 12'h000;
  // Released bus toggles every cycle so a stale word never looks valid
  assign bus_out = drive ? wdata : dut_oe_in ? dut_data_in : ~last;
  always @(posedge sys_clk_in) last <= bus_out;
  initial {select_low_n_out, select_high_out, access_out, read_n_out} = 4'hB;
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
    #5;
  endtask : cyc
  // Strobe low before select, so combined mode never sees a read
  task automatic host_write(input logic [1:0] addr, input logic [CTRL_W-1:0] val, input logic lo_n, hi);
    wdata = {addr, val};
    drive = 1'h1;
    access_out = 1'h0;
    cyc(4);
    select_low_n_out = lo_n;
    select_high_out = hi;
    cyc(6);
    {select_low_n_out, select_high_out} = 2'h2;
    cyc(4);
    access_out = 1'h1;
    drive = 1'h0;
    cyc(8);
  endtask : host_write
  // Strobe held until the enable is seen at an edge; unanswered read gives X
  task automatic host_read(input logic sep, output logic [DATA_W-1:0] val);
    int n;
    val = 12'hXXX;
    {select_low_n_out, select_high_out} = 2'h1;
    read_n_out = ~sep;
    for (n = 0; n < 12; n++) begin
      @(posedge sys_clk_in);
      if (dut_oe_in === 1'h1) begin
        val = bus_out;
        break;
      end
    end
    #5;
    {select_low_n_out, select_high_out, read_n_out} = 3'h5;
    for (n = 0; n < 12 && dut_oe_in !== 1'h0; n++) @(posedge sys_clk_in);
    cyc(6);
  endtask : host_read
endmodule : ahp_host_model
`default_nettype wire

// ### verification/ahp_host_port_tb.sv
// Self-checking bench for the converter parallel host port
`default_nettype none
module ahp_host_port_tb;
  import ahp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_in = 1'h0, rstn_in = 1'h0, conv = 1'h0, seen_oe = 1'h0, last_sync, exp_ovr = 1'h0;
  logic sel_lo_n, sel_hi, acc, rd_n, oe, sync_n, ref_ext, ovr;
  logic [DATA_W-1:0] bus, dout, sample = 12'h000, last_word = 12'h000;
  logic [CTRL_W-1:0] c0, c1, v0;
  logic [DATA_W-1:0] pipe[$], fifo[$];
  logic [DATA_W-1:0] dout_unused;
  logic sy[8];
  int n_mismatch = 0, total_checks = 0, cycles = 0, k, p;
  ahp_host_port dut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .conversion_clock_in(conv),
    .select_low_n_in(sel_lo_n), .select_high_in(sel_hi), .access_in(acc), .read_n_in(rd_n),
    .data_in(bus), .sample_in(sample), .data_out(dout), .data_oe_out(oe), .sync_n_out(sync_n),
    .ref_external_out(ref_ext), .control0_out(c0), .control1_out(c1), .overrun_out(ovr));
  ahp_host_model host (.sys_clk_in(sys_clk_in), .dut_data_in(dout), .dut_oe_in(oe),
    .select_low_n_out(sel_lo_n), .select_high_out(sel_hi), .access_out(acc), .read_n_out(rd_n),
    .bus_out(bus));
  initial forever #50 sys_clk_in = ~sys_clk_in;
  // Timeout keeps a stuck handshake from hanging the run
  always @(posedge sys_clk_in) begin
    cycles++;
    if (oe === 1'h1) seen_oe <= 1'h1;
    if (cycles == 6000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  // ----------------------------------------
  // Compare and verdict
  // ----------------------------------------
  task automatic check_word(input string what, input logic [DATA_W-1:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word
  task automatic check_ctrl(input string what, input logic [CTRL_W-1:0] exp, got);
    check_word(what, {2'h0, exp}, {2'h0, got});
  endtask : check_ctrl
  task automatic check_bit(input string what, input logic exp, got);
    check_word(what, {11'h000, exp}, {11'h000, got});
  endtask : check_bit
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  // ----------------------------------------
  // Conversion clock and expected result queue
  // ----------------------------------------
  // Sample changes mid-period so the capture never sees it move
  task automatic conv_periods(input int n);
    repeat (n) begin
      @(posedge sys_clk_in);
      #5 conv = 1'h1;
      sample = DATA_W'($urandom);
      repeat (8) @(posedge sys_clk_in);
      #5 conv = 1'h0;
      pipe.push_back(sample);
      if (pipe.size() > PIPE_DEPTH) begin
        if (fifo.size() < FIFO_DEPTH) fifo.push_back(pipe[0]);
        else exp_ovr = 1'h1;
        pipe.delete(0);
      end
      repeat (8) @(posedge sys_clk_in);
      #5;
    end
  endtask : conv_periods
  // Empty buffer repeats the previous word
  task automatic read_check(input logic sep, multi);
    logic [DATA_W-1:0] got;
    host.host_read(sep, got);
    if (fifo.size() > 0) last_word = fifo.pop_front();
    last_sync = sync_n;
    check_word("read data", last_word, got);
    check_bit("bus enable idle", 1'h0, oe);
    if (!multi) check_bit("sync single", 1'h1, sync_n);
  endtask : read_check
  initial begin
    void'($urandom(32'h3DBEB1A5));
    repeat (6) @(posedge sys_clk_in);
    #5 rstn_in = 1'h1;
    check_bit("reset enable", 1'h0, oe);
    check_bit("reset sync", 1'h1, sync_n);
    check_ctrl("reset control1", CTRL1_RESET, c1);
    host.host_write(ADDR_CTRL1, 10'h000, 1'h0, 1'h1);
    check_ctrl("control1", 10'h000, c1);
    for (k = 0; k < 2; k++) begin
      v0 = (CTRL_W'($urandom) & 10'h3F8) | CTRL_W'(k);
      host.host_write(ADDR_CTRL0, v0, 1'h0, 1'h1);
      check_ctrl("control0", v0, c0);
      check_bit("reference select", v0[CTRL0_REF_EXT], ref_ext);
    end
    // Bad addresses and missing selects must leave both registers alone
    for (k = 0; k < 4; k++) begin
      host.host_write(k < 2 ? 2'(k + 2) : ADDR_CTRL0, CTRL_W'($urandom), k == 2, k != 3);
      check_ctrl("control0 kept", v0, c0);
      check_ctrl("control1 kept", 10'h000, c1);
    end
    conv_periods(5);
    read_check(1'h0, 1'h0);
    conv_periods(1);
    read_check(1'h0, 1'h0);
    conv_periods(12);
    check_bit("overrun", exp_ovr, ovr);
    repeat (9) read_check(1'h0, 1'h0);
    host.host_write(ADDR_CTRL0, 10'h006, 1'h0, 1'h1);
    host.host_write(ADDR_CTRL1, 10'h001, 1'h0, 1'h1);
    check_ctrl("control1 separate", 10'h001, c1);
    seen_oe = 1'h0;
    host.host_read(1'h0, dout_unused);
    check_bit("direction read ignored", 1'h0, seen_oe);
    while (fifo.size() > 0) read_check(1'h1, 1'h1);
    conv_periods(5);
    while (fifo.size() > 0) read_check(1'h1, 1'h1);
    conv_periods(8);
    for (k = 0; k < 8; k++) begin
      read_check(1'h1, 1'h1);
      sy[k] = last_sync;
    end
    p = 0;
    for (k = 3; k >= 0; k--) if (sy[k] === 1'h0) p = k;
    for (k = 0; k < 8; k++) check_bit("sync marker", ((k - p) % 4) != 0, sy[k]);
    // Write through the dedicated strobe once separate mode is in force
    host.host_write(ADDR_CTRL0, 10'h001, 1'h0, 1'h1);
    check_ctrl("control0 separate write", 10'h001, c0);
    check_bit("reference external", 1'h1, ref_ext);
    give_verdict();
  end
endmodule : ahp_host_port_tb
`default_nettype wire
